// file: tc_pkg.sv
// Shared constants of the 16-bit timer/counter: register indices, control
// field positions, reset values and bus codes.
// Assumes a single 125 MHz clock domain and word-aligned AHB-Lite access.
package tc_pkg;

    // ****************************************************************
    // Register map: index, byte address is four times the index
    // ****************************************************************
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_MSB = 9;
    localparam logic [7:0] IDX_FLAG = 8'h0C;
    localparam logic [7:0] IDX_CNT_LO = 8'h0E;
    localparam logic [7:0] IDX_CNT_HI = 8'h0F;
    localparam logic [7:0] IDX_CTRL = 8'h10;
    localparam logic [7:0] IDX_IE = 8'h8C;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int unsigned CTRL_RUN = 0;
    localparam int unsigned CTRL_CS = 1;
    localparam int unsigned CTRL_NOSYNC = 2;
    localparam int unsigned CTRL_OSCEN = 3;
    localparam int unsigned CTRL_PS_LSB = 4;
    localparam int unsigned CTRL_PS_MSB = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'h3F;
    localparam int unsigned FLAG_BIT = 0;

    // ****************************************************************
    // Counter values and bus codes
    // ****************************************************************
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [1:0] MAP_HI_ZERO = 2'h0;
    localparam logic [1:0] PINS_INPUT = 2'h3;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned PRE_BITS = 3;

endpackage

// file: tc_sync.sv
// Two-stage level synchroniser for asynchronous pin inputs.
// Assumes the inputs are slow compared with clk_sys.
module tc_sync #(
    parameter int unsigned W = 2
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
    } tc_sync_s;

    tc_sync_s st;
    tc_sync_s next_st;

    if (W < 1) begin : g_chk
        $error("tc_sync: width must be at least one");
    end

    // First stage feeds only the second stage
    always_comb begin
        next_st = st;
        next_st.ff1 = d;
        next_st.ff2 = st.ff1;
    end

    // State register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign q = st.ff2;

endmodule

// file: tc_prescale.sv
// Input prescaler: divides count pulses by 1, 2, 4 or 8.
// Assumes pulse_in is a one-cycle pulse on clk_sys.
module tc_prescale #(
    parameter int unsigned BITS = tc_pkg::PRE_BITS
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic clr,
    input wire logic pulse_in,
    input wire logic [1:0] ratio,
    output logic tick_out
);

    typedef struct packed {
        logic [BITS-1:0] cnt;
    } tc_pre_s;

    tc_pre_s st;
    tc_pre_s next_st;
    logic [BITS-1:0] mask;

    if (BITS < 3) begin : g_chk
        $error("tc_prescale: needs three bits for the 1:8 ratio");
    end

    // Low-bit mask that must be all ones before a tick passes
    function automatic logic [BITS-1:0] ratio_mask(input logic [1:0] r);
        logic [BITS-1:0] m;
        m = '0;
        unique case (r)
            2'h0: m = '0;
            2'h1: m[0] = 1'b1;
            2'h2: m[1:0] = 2'h3;
            2'h3: m[2:0] = 3'h7;
        endcase
        return m;
    endfunction

    assign mask = ratio_mask(ratio);
    assign tick_out = pulse_in && ((st.cnt & mask) == mask);

    // Ripple count of input edges, cleared by a count write
    always_comb begin
        next_st = st;
        if (clr) begin
            next_st.cnt = '0;
        end else if (pulse_in) begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_presc_clear: assert property (ce && clr |=> st.cnt == '0)
        else $error("prescaler not cleared by count write");
    a_div8_tick: assert property (tick_out && ratio == 2'h3 |-> st.cnt[2:0] == 3'h7)
        else $error("1:8 tick before eighth edge");

endmodule

// file: tc_timer16.sv
// 16-bit timer/counter with prescaler, pin synchronisation, crystal
// oscillator control and an AHB-Lite register slave.
// Assumes one clk_sys domain, a core instruction tick and compare unit
// triggers on clk_sys, and count pins that are asynchronous.

// Contract
// - 16-bit count wraps from all ones to zero
// - Wrap sets overflow flag; enable gates interrupt
// - Source select: external rising edges or instruction clock
// - Internal source advances once per instruction cycle
// - Sync bit ignored with internal source
// - Run bit starts and stops counting
// - Prescale field divides by 1, 2, 4, 8
// - Oscillator enable powers the crystal amplifier
// - Oscillator on forces pins input, reads zero
// - Sync-disable bit bypasses phase-clock synchronisation; here pins are always synced and the bit only lets counting run in sleep
// - Falling edge needed before first counted rise
// - Count pin: oscillator input or external clock
// - Synchronisation follows a ripple prescaler; here the pins are synced before the prescaler
// - Synced counter holds in sleep; prescaler runs
// - Compare unit triggers reset the count
// - Control bits seven and six read zero
// - Unsynced counter keeps running during sleep
// - Count byte write clears the prescaler
// - Count write beats coincident trigger reset
// - Power-on reset clears the control register
module tc_timer16 (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [tc_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic instr_tick,
    input wire logic sleep_mode,
    input wire logic ccp1_trig,
    input wire logic ccp2_trig,
    input wire logic osc_input_pin,
    input wire logic ext_count_clock_pin,
    input wire logic [1:0] port_c_direction,
    output logic osc_amp_en,
    output logic [1:0] osc_pin_oe_n,
    output logic pin_read_zero,
    output logic [15:0] count_value,
    output logic irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] count;
        logic ovf_flag;
        logic ovf_ie;
        logic irq;
        logic src_prev;
        logic armed;
        logic a_pend;
        logic a_write;
        logic a_map;
        logic [7:0] a_idx;
        logic hready;
        logic [31:0] hrdata;
        logic osc_amp_en;
        logic [1:0] oe_n;
        logic rd_zero;
    } tc_state_s;

    localparam tc_state_s ST_RESET = '{
        ctrl: tc_pkg::CTRL_RESET,
        count: tc_pkg::CNT_ZERO,
        hready: 1'b1,
        oe_n: tc_pkg::PINS_INPUT,
        default: '0
    };

    tc_state_s st;
    tc_state_s next_st;

    logic [1:0] pins_sync;
    logic run;
    logic ext_src;
    logic no_sync;
    logic osc_on;
    logic cnt_pin;
    logic rise;
    logic fall;
    logic pre_pulse;
    logic pre_tick;
    logic inc_ok;
    logic acc;
    logic wr_now;
    logic cnt_wr;
    logic evt;
    logic ovf_evt;

    // Register hit test shared by write and read decode
    function automatic logic reg_hit(input logic map, input logic [7:0] idx,
                                     input logic [7:0] want);
        return map && (idx == want);
    endfunction

    // ****************************************************************
    // Pin synchronisers and prescaler
    // ****************************************************************
    tc_sync #(.W(tc_pkg::SYNC_STAGES)) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .d({osc_input_pin, ext_count_clock_pin}),
        .q(pins_sync)
    );

    tc_prescale #(.BITS(tc_pkg::PRE_BITS)) u_pre (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .clr(cnt_wr),
        .pulse_in(pre_pulse),
        .ratio(st.ctrl[tc_pkg::CTRL_PS_MSB:tc_pkg::CTRL_PS_LSB]),
        .tick_out(pre_tick)
    );

    // ****************************************************************
    // Count source decode
    // ****************************************************************
    // Control fields and selected count pin
    assign run = st.ctrl[tc_pkg::CTRL_RUN];
    assign ext_src = st.ctrl[tc_pkg::CTRL_CS];
    assign no_sync = st.ctrl[tc_pkg::CTRL_NOSYNC];
    assign osc_on = st.ctrl[tc_pkg::CTRL_OSCEN];
    assign cnt_pin = osc_on ? pins_sync[1] : pins_sync[0];
    assign rise = cnt_pin && !st.src_prev;
    assign fall = !cnt_pin && st.src_prev;

    // Prescaler input: armed rising edge or instruction tick
    assign pre_pulse = run && (ext_src ? (rise && st.armed)
                                       : (instr_tick && !sleep_mode));
    // Synced external mode holds the counter in sleep
    assign inc_ok = pre_tick && !(ext_src && !no_sync && sleep_mode);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // Address phase accept and write data phase strobes
    assign acc = hsel && hready && htrans[1];
    assign wr_now = st.a_pend && st.a_write;
    assign cnt_wr = wr_now && (reg_hit(st.a_map, st.a_idx, tc_pkg::IDX_CNT_LO) ||
                               reg_hit(st.a_map, st.a_idx, tc_pkg::IDX_CNT_HI));
    assign evt = ccp1_trig || ccp2_trig;
    assign ovf_evt = !cnt_wr && !evt && inc_ok && (st.count == tc_pkg::CNT_MAX);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        next_st.src_prev = cnt_pin;
        // Arm only after a falling edge while running as a counter
        if (!run || !ext_src) begin
            next_st.armed = 1'b0;
        end else if (fall) begin
            next_st.armed = 1'b1;
        end
        // Count: write first, then trigger reset, then increment
        if (cnt_wr) begin
            if (st.a_idx == tc_pkg::IDX_CNT_LO) begin
                next_st.count[7:0] = hwdata[7:0];
            end else begin
                next_st.count[15:8] = hwdata[7:0];
            end
        end else if (evt) begin
            next_st.count = tc_pkg::CNT_ZERO;
        end else if (inc_ok) begin
            next_st.count = st.count + tc_pkg::CNT_ONE;
        end
        // Control and enable writes
        if (wr_now && reg_hit(st.a_map, st.a_idx, tc_pkg::IDX_CTRL)) begin
            next_st.ctrl = hwdata[7:0] & tc_pkg::CTRL_WMASK;
        end
        if (wr_now && reg_hit(st.a_map, st.a_idx, tc_pkg::IDX_IE)) begin
            next_st.ovf_ie = hwdata[tc_pkg::FLAG_BIT];
        end
        // Sticky flag, a wrap wins over a software clear
        if (wr_now && reg_hit(st.a_map, st.a_idx, tc_pkg::IDX_FLAG)) begin
            next_st.ovf_flag = hwdata[tc_pkg::FLAG_BIT];
        end
        if (ovf_evt) begin
            next_st.ovf_flag = 1'b1;
        end
        // Address phase capture
        next_st.a_pend = acc;
        if (acc) begin
            next_st.a_write = hwrite;
            next_st.a_idx = haddr[tc_pkg::IDX_MSB:tc_pkg::IDX_LSB];
            next_st.a_map = (haddr[tc_pkg::ADDR_W-1:tc_pkg::IDX_MSB+1] == tc_pkg::MAP_HI_ZERO)
                && (haddr[1:0] == 2'h0);
        end
        // Reads take one wait state so a prior write is visible
        if (acc && !hwrite) begin
            next_st.hready = 1'b0;
        end
        if (!st.hready) begin
            next_st.hready = 1'b1;
            next_st.hrdata = 32'h0000_0000;
            if (reg_hit(st.a_map, st.a_idx, tc_pkg::IDX_CTRL)) begin
                next_st.hrdata[7:0] = st.ctrl;
            end
            if (reg_hit(st.a_map, st.a_idx, tc_pkg::IDX_CNT_LO)) begin
                next_st.hrdata[7:0] = st.count[7:0];
            end
            if (reg_hit(st.a_map, st.a_idx, tc_pkg::IDX_CNT_HI)) begin
                next_st.hrdata[7:0] = st.count[15:8];
            end
            if (reg_hit(st.a_map, st.a_idx, tc_pkg::IDX_FLAG)) begin
                next_st.hrdata[tc_pkg::FLAG_BIT] = st.ovf_flag;
            end
            if (reg_hit(st.a_map, st.a_idx, tc_pkg::IDX_IE)) begin
                next_st.hrdata[tc_pkg::FLAG_BIT] = st.ovf_ie;
            end
        end
        // Registered outputs follow the next control and flag state
        next_st.irq = next_st.ovf_flag && next_st.ovf_ie;
        next_st.osc_amp_en = next_st.ctrl[tc_pkg::CTRL_OSCEN];
        next_st.rd_zero = next_st.ctrl[tc_pkg::CTRL_OSCEN];
        next_st.oe_n = next_st.ctrl[tc_pkg::CTRL_OSCEN] ? tc_pkg::PINS_INPUT
                                                        : port_c_direction;
    end

    // State register; power-on reset clears control
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= ST_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Outputs straight from state flip-flops, hresp tied low
    assign hreadyout = st.hready;
    assign hresp = 1'b0;
    assign hrdata = st.hrdata;
    assign osc_amp_en = st.osc_amp_en;
    assign osc_pin_oe_n = st.oe_n;
    assign pin_read_zero = st.rd_zero;
    assign count_value = st.count;
    assign irq = st.irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_wrap_flag: assert property (
        ce && ovf_evt |=> st.ovf_flag && st.count == tc_pkg::CNT_ZERO)
        else $error("wrap did not clear count and set flag");
    a_irq_gate: assert property (
        ce && ovf_evt && st.ovf_ie && !wr_now |=> irq)
        else $error("enabled overflow did not raise irq");
    a_timer_step: assert property (
        ce && run && !ext_src && instr_tick && !sleep_mode && !cnt_wr && !evt
        && st.ctrl[tc_pkg::CTRL_PS_MSB:tc_pkg::CTRL_PS_LSB] == 2'h0
        |=> st.count == $past(st.count) + tc_pkg::CNT_ONE)
        else $error("timer mode missed instruction tick");
    a_pin_step: assert property (
        ce && run && ext_src && st.armed && rise && (no_sync || !sleep_mode)
        && !cnt_wr && !evt && st.ctrl[tc_pkg::CTRL_PS_MSB:tc_pkg::CTRL_PS_LSB] == 2'h0
        |=> st.count == $past(st.count) + tc_pkg::CNT_ONE)
        else $error("counter mode missed rising pin edge");
    a_run_halt: assert property (
        ce && !run && !cnt_wr && !evt |=> $stable(st.count))
        else $error("count moved while stopped");
    a_pins_input: assert property (
        st.osc_amp_en |-> osc_pin_oe_n == tc_pkg::PINS_INPUT && pin_read_zero)
        else $error("oscillator pins not forced to input");
    a_fall_first: assert property (
        ce && ext_src && !st.armed && !cnt_wr && !evt |=> $stable(st.count))
        else $error("count advanced before falling edge");
    a_sleep_hold: assert property (
        ce && ext_src && !no_sync && sleep_mode && !cnt_wr && !evt |=> $stable(st.count))
        else $error("synced counter advanced in sleep");
    a_trig_reset: assert property (
        ce && evt && !cnt_wr |=> st.count == tc_pkg::CNT_ZERO)
        else $error("trigger did not reset count");
    a_write_wins: assert property (
        ce && evt && cnt_wr && st.a_idx == tc_pkg::IDX_CNT_LO
        |=> st.count[7:0] == $past(hwdata[7:0]))
        else $error("trigger overrode count write");
    a_ctrl_top_zero: assert property (
        st.ctrl[7:6] == 2'h0)
        else $error("unimplemented control bits set");
    a_flag_sticky: assert property (
        ce && st.ovf_flag && !wr_now |=> st.ovf_flag)
        else $error("overflow flag cleared without write");

endmodule

// file: tc_clk_src.sv
// Far-side model: clock source or crystal feeding the two count pins.
// Assumes the bench calls pulses() and that both pins idle low between bursts.
module tc_clk_src (
    output logic osc_input_pin,
    output logic ext_count_clock_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // Both pins stand still and low outside bursts
    initial begin
        osc_input_pin = 1'h0;
        ext_count_clock_pin = 1'h0;
    end

    // Burst of n full periods on one pin, off the bench clock grid
    task automatic pulses(input logic use_osc, input int n, input int half_ns);
        #3;
        repeat (n) begin
            if (use_osc) begin
                osc_input_pin = 1'h1;
                #(half_ns) osc_input_pin = 1'h0;
            end else begin
                ext_count_clock_pin = 1'h1;
                #(half_ns) ext_count_clock_pin = 1'h0;
            end
            #(half_ns);
        end
    endtask
endmodule

// file: test_timer16_counter_with_osc.sv
// Self-checking bench of the 16-bit timer/counter: registers over AHB-Lite,
// internal and pin counting, prescale, overflow, triggers and sleep.
// Assumes tc_pkg, tc_timer16 and the clock source model tc_clk_src.
`define CHK(got, want) begin total_checks++; if ((got) !== (want)) begin fails++; \
    $display("wrong value at %0t ns: got %0h want %0h", $time, got, want); end end
module test_timer16_counter_with_osc;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic clk_sys, nrst, ce, hsel, hwrite, hreadyout, hresp, instr_tick;
    logic sleep_mode, ccp1_trig, ccp2_trig, osc_input_pin, ext_count_clock_pin;
    logic osc_amp_en, pin_read_zero, irq, rd_phase;
    logic [tc_pkg::ADDR_W-1:0] haddr;
    logic [1:0] htrans, port_c_direction, osc_pin_oe_n;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, want_v;
    logic [15:0] count_value;
    logic [7:0] r;
    logic [31:0] exp_q[$];
    int fails, total_checks, seed;

    tc_timer16 i_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instr_tick(instr_tick),
        .sleep_mode(sleep_mode), .ccp1_trig(ccp1_trig), .ccp2_trig(ccp2_trig),
        .osc_input_pin(osc_input_pin), .ext_count_clock_pin(ext_count_clock_pin),
        .port_c_direction(port_c_direction), .osc_amp_en(osc_amp_en),
        .osc_pin_oe_n(osc_pin_oe_n), .pin_read_zero(pin_read_zero),
        .count_value(count_value), .irq(irq));
    tc_clk_src i_src (.osc_input_pin(osc_input_pin), .ext_count_clock_pin(ext_count_clock_pin));

    // 125 MHz clock
    initial clk_sys = 1'h0;
    always #4 clk_sys = ~clk_sys;

    // ****************************************************************
    // Bus tasks and helpers
    // ****************************************************************
    task automatic bus_wr(input logic [7:0] idx, input logic [31:0] d, input logic trig);
        hsel <= 1'h1;
        haddr <= {2'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= 1'h1;
        do @(posedge clk_sys); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        ccp1_trig <= trig;
        do @(posedge clk_sys); while (hreadyout !== 1'h1);
        if (trig) begin
            ccp1_trig <= 1'h0;
        end
    endtask

    // Read: expected word goes on the queue, the monitor compares it
    task automatic bus_rd(input logic [7:0] idx, input logic [31:0] want);
        exp_q.push_back(want);
        hsel <= 1'h1;
        haddr <= {2'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= 1'h0;
        do @(posedge clk_sys); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        do @(posedge clk_sys); while (hreadyout !== 1'h1);
    endtask

    task automatic ctl(input logic [7:0] v);
        bus_wr(tc_pkg::IDX_CTRL, {24'h000000, v}, 1'h0);
    endtask

    task automatic set_cnt(input logic [15:0] v);
        bus_wr(tc_pkg::IDX_CNT_HI, {24'h000000, v[15:8]}, 1'h0);
        bus_wr(tc_pkg::IDX_CNT_LO, {24'h000000, v[7:0]}, 1'h0);
    endtask

    task automatic chk_cnt(input logic [15:0] v);
        `CHK(count_value, v)
        bus_rd(tc_pkg::IDX_CNT_LO, {24'h000000, v[7:0]});
        bus_rd(tc_pkg::IDX_CNT_HI, {24'h000000, v[15:8]});
    endtask

    // Exactly n instruction-cycle pulses, one every two clocks
    task automatic tick(input int n);
        repeat (n) begin
            instr_tick <= 1'h1;
            @(posedge clk_sys);
            instr_tick <= 1'h0;
            @(posedge clk_sys);
        end
    endtask

    task automatic settle();
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic wrap_up();
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Monitor: a read data phase ending with ready high yields a result
    always @(posedge clk_sys) begin
        if (rd_phase && hreadyout === 1'h1 && exp_q.size() > 0) begin
            want_v = exp_q.pop_front();
            `CHK(hrdata, want_v)
        end
        if (hreadyout === 1'h1) begin
            rd_phase <= hsel && htrans[1] && !hwrite && nrst;
        end
    end

    // Watchdog cuts a hang short
    initial begin
        #200000;
        fails++;
        wrap_up();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        seed = 27;
        {nrst, hsel, hwrite, instr_tick, sleep_mode, ccp1_trig, ccp2_trig} = '0;
        ce = 1'h1;
        haddr = '0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        port_c_direction = 2'($random(seed));
        r = 8'($random(seed)) & 8'h07;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'h1;
        @(posedge clk_sys);
        // Reset state and register access
        `CHK(osc_amp_en, 1'h0)
        bus_rd(tc_pkg::IDX_CTRL, 32'h00000000);
        bus_rd(tc_pkg::IDX_FLAG, 32'h00000000);
        ctl(8'hFF);
        bus_rd(tc_pkg::IDX_CTRL, 32'h0000003F);
        ctl(8'h00);
        bus_wr(8'h20, 32'hFFFFFFFF, 1'h0);
        bus_rd(8'h20, 32'h00000000);
        // Every prescale ratio on the instruction clock, then run off
        for (int ps = 0; ps < 4; ps++) begin
            set_cnt(16'h0000);
            ctl({2'h0, 2'(ps), 4'h1});
            tick(16);
            ctl(8'h00);
            tick(3);
            chk_cnt(16'(16 >> ps));
        end
        set_cnt(16'h0000);
        ctl(8'h05);
        tick(5);
        ctl(8'h00);
        chk_cnt(16'h0005);
        // Wrap from all ones, flag and interrupt enable
        set_cnt({8'hFF, 8'hFF - r});
        ctl(8'h01);
        tick(int'(r) + 3);
        ctl(8'h00);
        chk_cnt(16'h0002);
        `CHK(irq, 1'h0)
        bus_wr(tc_pkg::IDX_IE, 32'h00000001, 1'h0);
        settle();
        `CHK(irq, 1'h1)
        bus_rd(tc_pkg::IDX_FLAG, 32'h00000001);
        bus_wr(tc_pkg::IDX_FLAG, 32'h00000000, 1'h0);
        settle();
        `CHK(irq, 1'h0)
        set_cnt(16'hFFFF);
        ctl(8'h01);
        tick(1);
        ctl(8'h00);
        `CHK(irq, 1'h1)
        bus_wr(tc_pkg::IDX_FLAG, 32'h00000000, 1'h0);
        bus_wr(tc_pkg::IDX_IE, 32'h00000000, 1'h0);
        // Pin counting: first rise waits for a fall, other pin ignored
        set_cnt(16'h0000);
        ctl(8'h03);
        fork
            i_src.pulses(1'h0, 5, 40);
            i_src.pulses(1'h1, 3, 56);
        join
        settle();
        ctl(8'h00);
        chk_cnt(16'h0004);
        set_cnt(16'h0000);
        ctl(8'h13);
        i_src.pulses(1'h0, 9, 40);
        settle();
        ctl(8'h00);
        chk_cnt(16'h0004);
        // Oscillator on: pin source, amplifier, pin directions
        set_cnt(16'h0000);
        ctl(8'h0B);
        fork
            i_src.pulses(1'h1, 3, 40);
            i_src.pulses(1'h0, 2, 48);
        join
        settle();
        `CHK(osc_amp_en, 1'h1)
        `CHK(osc_pin_oe_n, 2'h3)
        `CHK(pin_read_zero, 1'h1)
        ctl(8'h00);
        chk_cnt(16'h0002);
        `CHK(osc_amp_en, 1'h0)
        `CHK(osc_pin_oe_n, port_c_direction)
        // Sleep: synced counting holds, unsynced keeps going
        set_cnt(16'h0000);
        sleep_mode <= 1'h1;
        ctl(8'h03);
        i_src.pulses(1'h0, 4, 40);
        settle();
        ctl(8'h00);
        chk_cnt(16'h0000);
        ctl(8'h07);
        i_src.pulses(1'h0, 4, 40);
        settle();
        ctl(8'h00);
        chk_cnt(16'h0003);
        sleep_mode <= 1'h0;
        // Compare-unit triggers, and a write that coincides with one
        set_cnt(16'h1234);
        ccp1_trig <= 1'h1;
        @(posedge clk_sys);
        ccp1_trig <= 1'h0;
        settle();
        chk_cnt(16'h0000);
        set_cnt(16'h00AB);
        ccp2_trig <= 1'h1;
        @(posedge clk_sys);
        ccp2_trig <= 1'h0;
        settle();
        chk_cnt(16'h0000);
        bus_wr(tc_pkg::IDX_CNT_HI, 32'h00000056, 1'h0);
        bus_wr(tc_pkg::IDX_CNT_LO, 32'h00000078, 1'h1);
        settle();
        chk_cnt(16'h5678);
        settle();
        `CHK(exp_q.size(), 0)
        wrap_up();
    end
endmodule
